// ==== core/fcd_clock_network.sv ====
`timescale 1ns/1ps
module fcd_clock_network (
   input  wire logic                                   clk_sys,
   input  wire logic                                   srst,
   input  wire fcd_pkg::fcd_cfg_s                      cfgImage,
   input  wire logic [fcd_pkg::NUM_SRC-1:0]            clkSrc,
   input  wire logic [fcd_pkg::ROUTE_W-1:0]            routeSig,
   input  wire logic [fcd_pkg::NUM_DYN-1:0]            dynSel,
   output fcd_pkg::fcd_net_s                           clkNet,
   output logic [fcd_pkg::NUM_DYN-1:0]                 dynActive
);

   // Centre mux pick
   function automatic logic pickSrc(input logic [fcd_pkg::NUM_SRC-1:0]   src,
                                    input logic [fcd_pkg::SRC_SEL_W-1:0] sel);
      pickSrc = src[sel];
   endfunction : pickSrc

   fcd_pkg::fcd_cfg_s                    cfg_q;
   fcd_pkg::fcd_cfg_s                    cfg_d;
   fcd_pkg::fcd_net_s                    net_q;
   fcd_pkg::fcd_net_s                    net_d;
   logic [fcd_pkg::NUM_DYN-1:0]          selMeta_q;
   logic [fcd_pkg::NUM_DYN-1:0]          selSync_q;
   logic [fcd_pkg::NUM_DYN-1:0]          curSel_q;
   logic [fcd_pkg::NUM_DYN-1:0]          curSel_d;
   fcd_pkg::fcd_selst_e                  selSt_q [fcd_pkg::NUM_DYN];
   fcd_pkg::fcd_selst_e                  selSt_d [fcd_pkg::NUM_DYN];

   logic [fcd_pkg::NUM_DYN-1:0][1:0]     dynIn;
   logic [fcd_pkg::SEC_LINES-1:0]        secLine;

   // Configuration is captured only while reset is held
   always_comb begin
      cfg_d = srst ? cfgImage : cfg_q;
   end

   // Centre muxes for dynamic selector inputs and secondary lines
   always_comb begin
      for (int k = 0; k < fcd_pkg::NUM_DYN; k++) begin
         for (int j = 0; j < 2; j++) begin
            dynIn[k][j] = pickSrc(clkSrc, cfg_q.dynInSel[k][j]);
         end
      end
      for (int s = 0; s < fcd_pkg::SEC_LINES; s++) begin
         secLine[s] = pickSrc(clkSrc, cfg_q.secSel[s]);
      end
   end

   // Glitch-free selectors
   always_comb begin
      logic curClk;
      logic newClk;
      curClk = 1'b0;
      newClk = 1'b0;
      curSel_d = curSel_q;
      dynActive = '0;
      for (int k = 0; k < fcd_pkg::NUM_DYN; k++) begin
         selSt_d[k] = selSt_q[k];
         curClk = dynIn[k][curSel_q[k]];
         newClk = dynIn[k][selSync_q[k]];
         dynActive[k] = (selSt_q[k] == fcd_pkg::FCD_SEL_RUN);
         case (selSt_q[k])
            fcd_pkg::FCD_SEL_RUN: begin
               // Leave only while the old clock is low
               if ((selSync_q[k] != curSel_q[k]) && !curClk) begin
                  selSt_d[k] = fcd_pkg::FCD_SEL_WAIT;
               end
            end
            fcd_pkg::FCD_SEL_WAIT: begin
               // Take the new clock only while it is low
               if (!newClk) begin
                  curSel_d[k] = selSync_q[k];
                  selSt_d[k]  = fcd_pkg::FCD_SEL_RUN;
               end
            end
            default: begin
               selSt_d[k] = fcd_pkg::FCD_SEL_RUN;
            end
         endcase
      end
   end

   // Network outputs
   always_comb begin
      logic [fcd_pkg::PRIM_LINES-1:0] primQ;
      logic [fcd_pkg::SCLK_SEL_W-1:0] cs;
      logic [fcd_pkg::SCTL_SEL_W-1:0] ts;
      primQ = '0;
      cs = fcd_pkg::SCLK_NONE;
      ts = fcd_pkg::SCTL_NONE;
      net_d = net_q;
      for (int q = 0; q < fcd_pkg::NUM_QUAD; q++) begin
         for (int l = 0; l < fcd_pkg::STAT_PRIM; l++) begin
            net_d.prim[q][l] = pickSrc(clkSrc, cfg_q.primSel[q][l]);
         end
         for (int d = 0; d < fcd_pkg::DYN_PER_Q; d++) begin
            // Old clock is low on entry to the wait state, so output stays low
            net_d.prim[q][fcd_pkg::DYN_FIRST+d] =
               (selSt_q[q*fcd_pkg::DYN_PER_Q+d] == fcd_pkg::FCD_SEL_RUN) &&
               dynIn[q*fcd_pkg::DYN_PER_Q+d][curSel_q[q*fcd_pkg::DYN_PER_Q+d]];
         end
      end
      for (int r = 0; r < fcd_pkg::NUM_REGION; r++) begin
         net_d.regionSec[r] = secLine[fcd_pkg::SEC_CLK-1:0];
      end
      net_d.fanout = secLine[fcd_pkg::SEC_LINES-1:fcd_pkg::SEC_CLK];
      primQ = net_q.prim[cfg_q.sliceQuad];
      // Slices zero to two only
      for (int s = 0; s < fcd_pkg::NUM_SLICE; s++) begin
         cs = cfg_q.sliceClkSel[s];
         if (cs == fcd_pkg::SCLK_NONE || cs > fcd_pkg::SCLK_LAST) begin
            net_d.sliceClk[s] = fcd_pkg::IDLE_LEVEL;
         end else if (cs < fcd_pkg::SCLK_SEC0) begin
            net_d.sliceClk[s] = primQ[3'(cs - fcd_pkg::SCLK_PRIM0)];
         end else if (cs < fcd_pkg::SCLK_RT0) begin
            net_d.sliceClk[s] = secLine[2'(cs - fcd_pkg::SCLK_SEC0)];
         end else begin
            net_d.sliceClk[s] = routeSig[2'(cs - fcd_pkg::SCLK_RT0)];
         end
         ts = cfg_q.sliceCtlSel[s];
         if (ts == fcd_pkg::SCTL_NONE || ts > fcd_pkg::SCTL_LAST) begin
            net_d.sliceCtl[s] = fcd_pkg::IDLE_LEVEL;
         end else if (ts < fcd_pkg::SCTL_RT0) begin
            net_d.sliceCtl[s] = secLine[2'(ts - fcd_pkg::SCTL_SEC0)];
         end else begin
            net_d.sliceCtl[s] = routeSig[2'(ts - fcd_pkg::SCTL_RT0)];
         end
      end
      for (int e = 0; e < fcd_pkg::NUM_EDGE; e++) begin
         net_d.edgeClk[e] = pickSrc(clkSrc, cfg_q.edgeSel[e]);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         net_q     <= '0;
         selMeta_q <= '0;
         selSync_q <= '0;
         curSel_q  <= '0;
         for (int k = 0; k < fcd_pkg::NUM_DYN; k++) begin
            selSt_q[k] <= fcd_pkg::FCD_SEL_RUN;
         end
      end else begin
         net_q     <= net_d;
         selMeta_q <= dynSel;
         selSync_q <= selMeta_q;
         curSel_q  <= curSel_d;
         for (int k = 0; k < fcd_pkg::NUM_DYN; k++) begin
            selSt_q[k] <= selSt_d[k];
         end
      end
      cfg_q <= cfg_d;
   end

   assign clkNet = net_q;

endmodule : fcd_clock_network

// ==== core/fcd_pkg.sv ====
package fcd_pkg;

   // Sizes of the network
   localparam int NUM_SRC     = 16;
   localparam int SRC_SEL_W   = 4;
   localparam int NUM_QUAD    = 4;
   localparam int PRIM_LINES  = 8;
   localparam int STAT_PRIM   = 6;
   localparam int DYN_PER_Q   = 2;
   localparam int NUM_DYN     = 8;
   localparam int DYN_FIRST   = 6;
   localparam int SEC_LINES   = 8;
   localparam int SEC_CLK     = 4;
   localparam int NUM_REGION  = 8;
   localparam int NUM_SLICE   = 3;
   localparam int ROUTE_W     = 4;
   localparam int NUM_EDGE    = 8;
   localparam int EDGE_PER_SD = 2;

   // Slice clock mux: code 0 none, 1..8 primary, 9..12 secondary, 13..16 routing
   localparam int SCLK_SEL_W  = 5;
   localparam logic [4:0] SCLK_NONE  = 5'h00;
   localparam logic [4:0] SCLK_PRIM0 = 5'h01;
   localparam logic [4:0] SCLK_SEC0  = 5'h09;
   localparam logic [4:0] SCLK_RT0   = 5'h0D;
   localparam logic [4:0] SCLK_LAST  = 5'h10;

   // Slice control mux: code 0 none, 1..4 secondary, 5..8 routing
   localparam int SCTL_SEL_W  = 4;
   localparam logic [3:0] SCTL_NONE  = 4'h0;
   localparam logic [3:0] SCTL_SEC0  = 4'h1;
   localparam logic [3:0] SCTL_RT0   = 4'h5;
   localparam logic [3:0] SCTL_LAST  = 4'h8;

   // Reset value and idle level of unselected slice muxes
   localparam logic       OUT_RST    = 1'b0;
   localparam logic       IDLE_LEVEL = 1'b1;

   typedef enum logic {
      FCD_SEL_RUN,
      FCD_SEL_WAIT
   } fcd_selst_e;

   // Static configuration image
   typedef struct packed {
      logic [NUM_QUAD-1:0][STAT_PRIM-1:0][SRC_SEL_W-1:0] primSel;
      logic [NUM_DYN-1:0][1:0][SRC_SEL_W-1:0]            dynInSel;
      logic [SEC_LINES-1:0][SRC_SEL_W-1:0]               secSel;
      logic [1:0]                                        sliceQuad;
      logic [NUM_SLICE-1:0][SCLK_SEL_W-1:0]              sliceClkSel;
      logic [NUM_SLICE-1:0][SCTL_SEL_W-1:0]              sliceCtlSel;
      logic [NUM_EDGE-1:0][SRC_SEL_W-1:0]                edgeSel;
   } fcd_cfg_s;

   // Driven clock network
   typedef struct packed {
      logic [NUM_QUAD-1:0][PRIM_LINES-1:0]  prim;
      logic [NUM_REGION-1:0][SEC_CLK-1:0]   regionSec;
      logic [SEC_LINES-SEC_CLK-1:0]         fanout;
      logic [NUM_SLICE-1:0]                 sliceClk;
      logic [NUM_SLICE-1:0]                 sliceCtl;
      logic [NUM_EDGE-1:0]                  edgeClk;
   } fcd_net_s;

endpackage : fcd_pkg

// ==== verification/fcd_src_model.sv ====
`timescale 1ns/1ps
module fcd_src_model (
   input  wire logic clk_sys,
   output logic [15:0] clkSrc,
   output logic [3:0]  routeSig
);
   logic [7:0] cnt_q = 8'h00;
   // Free-running sources, no two alike
   always_ff @(posedge clk_sys) begin
      cnt_q <= cnt_q + 8'h01;
   end
   assign clkSrc   = {cnt_q, ~cnt_q[3:0], ~cnt_q[7:4]};
   assign routeSig = cnt_q[3:0] ^ 4'h6;
endmodule : fcd_src_model

// ==== verification/fcd_clock_network_assertions.sv ====
`timescale 1ns/1ps
module fcd_net_checker (
   input wire logic                        clk_sys,
   input wire logic                        srst,
   input wire fcd_pkg::fcd_cfg_s           cfgImage,
   input wire logic [fcd_pkg::NUM_SRC-1:0] clkSrc,
   input wire fcd_pkg::fcd_net_s           clkNet,
   input wire logic [fcd_pkg::NUM_DYN-1:0] dynActive
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);
   property p_prim;
      !$past(srst) |-> clkNet.prim[3][5] == $past(clkSrc[cfgImage.primSel[3][5]]);
   endproperty
   a_prim: assert property (p_prim) else $error("primary line wrong");
   property p_sec;
      !$past(srst) |-> clkNet.regionSec[7][3] == $past(clkSrc[cfgImage.secSel[3]]);
   endproperty
   a_sec: assert property (p_sec) else $error("region line wrong");
   property p_fan;
      !$past(srst) |-> clkNet.fanout[0] == $past(clkSrc[cfgImage.secSel[4]]);
   endproperty
   a_fan: assert property (p_fan) else $error("fanout line wrong");
   property p_edge;
      !$past(srst) |-> clkNet.edgeClk[7] == $past(clkSrc[cfgImage.edgeSel[7]]);
   endproperty
   a_edge: assert property (p_edge) else $error("edge clock wrong");
   property p_slprim;
      cfgImage.sliceClkSel[1] == fcd_pkg::SCLK_PRIM0 && !$past(srst) && !$past(srst, 2)
      |-> clkNet.sliceClk[1] == $past(clkSrc[cfgImage.primSel[cfgImage.sliceQuad][0]], 2);
   endproperty
   a_slprim: assert property (p_slprim) else $error("slice clock wrong");
   property p_none;
      !$past(srst) && cfgImage.sliceCtlSel[0] == fcd_pkg::SCTL_NONE |-> clkNet.sliceCtl[0];
   endproperty
   a_none: assert property (p_none) else $error("idle mux not one");
   property p_bound; $fell(dynActive[0]) |-> ##[1:40] dynActive[0]; endproperty
   a_bound: assert property (p_bound) else $error("switch too long");
   property p_wait; !dynActive[0] && !$past(dynActive[0]) |-> !clkNet.prim[0][6]; endproperty
   a_wait: assert property (p_wait) else $error("line not held");
   c_switch: cover property ($rose(dynActive[0]));
   c_prim: cover property (cfgImage.sliceClkSel[1] == fcd_pkg::SCLK_PRIM0);
   c_route: cover property (cfgImage.sliceClkSel[2] == fcd_pkg::SCLK_RT0);
   c_dynline: cover property (cfgImage.sliceClkSel[0] == 5'h07);
endmodule : fcd_net_checker
bind fcd_clock_network fcd_net_checker chk_u (.clk_sys(clk_sys), .srst(srst),
   .cfgImage(cfgImage), .clkSrc(clkSrc), .clkNet(clkNet), .dynActive(dynActive));

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   logic              clk_sys = 1'b0;
   logic              srst = 1'b1;
   logic [7:0]        dynSel = 8'h00;
   logic [15:0]       clkSrc, h1, h2;
   logic [3:0]        routeSig, r1;
   logic [7:0]        dynActive;
   fcd_pkg::fcd_cfg_s cfg = '0;
   fcd_pkg::fcd_net_s clkNet;
   int                err_total = 0;
   int                comparisons = 0;
   logic [4:0] ckTab [12] = '{5'h00, 5'h01, 5'h06, 5'h09, 5'h0C, 5'h0D, 5'h10, 5'h11, 5'h1F,
                              5'h07, 5'h08, 5'h0E};
   logic [3:0] ctTab [12] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hF, 4'h2, 4'h6,
                              4'h3, 4'h7, 4'h0};
   initial forever #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      h2 <= h1;
      h1 <= clkSrc;
      r1 <= routeSig;
   end
   fcd_src_model src_u (.clk_sys(clk_sys), .clkSrc(clkSrc), .routeSig(routeSig));
   fcd_clock_network dut_u (.clk_sys(clk_sys), .srst(srst), .cfgImage(cfg), .clkSrc(clkSrc),
      .routeSig(routeSig), .dynSel(dynSel), .clkNet(clkNet), .dynActive(dynActive));
   task cmp(input logic g, input logic e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask : cmp
   function automatic logic exClk(input logic [4:0] c, input logic d);
      if (c == 5'h00 || c > 5'h10) return 1'b1;
      if (c < 5'h07) return h2[cfg.primSel[cfg.sliceQuad][c-5'h01]];
      if (c < 5'h09) return h2[cfg.dynInSel[2*cfg.sliceQuad+c-5'h07][d]];
      if (c < 5'h0D) return h1[cfg.secSel[c-5'h09]];
      return r1[c-5'h0D];
   endfunction : exClk
   function automatic logic exCtl(input logic [3:0] c);
      if (c == 4'h0 || c > 4'h8) return 1'b1;
      if (c < 4'h5) return h1[cfg.secSel[c-4'h1]];
      return r1[c-4'h5];
   endfunction : exCtl
   task chk(input logic d, input int n);
      repeat (n) begin
         @(negedge clk_sys);
         for (int i = 0; i < 24; i++) cmp(clkNet.prim[i/6][i%6], h1[cfg.primSel[i/6][i%6]]);
         for (int i = 0; i < 8; i++) begin
            cmp(clkNet.prim[i/2][6+i%2], h1[cfg.dynInSel[i][d]]);
            cmp(clkNet.edgeClk[i], h1[cfg.edgeSel[i]]);
            for (int k = 0; k < 4; k++) cmp(clkNet.regionSec[i][k], h1[cfg.secSel[k]]);
         end
         for (int k = 0; k < 4; k++) cmp(clkNet.fanout[k], h1[cfg.secSel[4+k]]);
         for (int s = 0; s < 3; s++) begin
            cmp(clkNet.sliceClk[s], exClk(cfg.sliceClkSel[s], d));
            cmp(clkNet.sliceCtl[s], exCtl(cfg.sliceCtlSel[s]));
         end
      end
   endtask : chk
   task boot(input int rd);
      @(posedge clk_sys);
      srst <= 1'b1;
      cfg.sliceQuad <= 2'(rd);
      for (int s = 0; s < 3; s++) begin
         cfg.sliceClkSel[s] <= ckTab[rd*3+s];
         cfg.sliceCtlSel[s] <= ctTab[rd*3+s];
      end
      repeat (5) @(posedge clk_sys);
      srst <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : boot
   task t_codes;
      for (int rd = 0; rd < 4; rd++) begin
         boot(rd);
         chk(1'b0, 20);
      end
      @(posedge clk_sys);
      cfg.edgeSel[0] <= 4'h4;
      repeat (4) begin
         @(negedge clk_sys);
         cmp(clkNet.edgeClk[0], h1[4'h1]);
      end
      @(posedge clk_sys);
      cfg.edgeSel[0] <= 4'h1;
      $display("test static_paths done");
   endtask : t_codes
   task t_dyn;
      logic [7:0] seen;
      for (int d = 1; d >= 0; d--) begin
         seen = 8'h00;
         @(posedge clk_sys);
         dynSel <= {8{d[0]}};
         for (int i = 0; i < 60 && !(&seen && &dynActive); i++) begin
            @(negedge clk_sys);
            seen = seen | ~dynActive;
         end
         cmp(&seen, 1'b1);
         cmp(&dynActive, 1'b1);
         repeat (2) @(posedge clk_sys);
         chk(d[0], 16);
      end
      $display("test dynamic_switch done");
   endtask : t_dyn
   task test_done;
      $display("totals: %0d comparisons, %0d mismatches", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : test_done
   initial begin
      for (int i = 0; i < 24; i++) cfg.primSel[i/6][i%6] = 4'(i);
      for (int i = 0; i < 8; i++) begin
         cfg.secSel[i] = 4'(15 - i);
         cfg.edgeSel[i] = 4'(2 * i + 1);
         cfg.dynInSel[i][0] = 4'(4 + i % 4);
         cfg.dynInSel[i][1] = 4'(8 + (i + 1) % 4);
      end
      t_codes();
      t_dyn();
      test_done();
   end
   initial begin
      #4000;
      err_total++;
      test_done();
   end
endmodule : testbench
